// *** design/psbs_ctrl.sv ***
// Power state command interpreter with bank selection and APB register file
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
module psbs_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        resetInLow,
  input  wire logic        bankSelectLoPin,
  input  wire logic        bankSelectHiPin,
  input  wire logic        playActive,
  input  wire logic        channelWaiting,
  output logic             commandBusyNPin,
  output logic             commandReadyFlag,
  output logic             playbackBusyFlag,
  output logic             ampPowered,
  output logic             dacPowered,
  output logic             speakerMinusOut,
  output logic             speakerMinusOutEnN,
  output logic [20:0]      romAddr,
  output logic [1:0]       bankCount
);

  ////////////////////////////////////////////////////////////////////////////
  // State image and helpers
  psbs_pkg::psbs_regs_t r;
  psbs_pkg::psbs_regs_t nxt;
  logic [20:0]          physAddr;
  logic                 wrAccess;
  logic                 cmdStrobe;
  logic [7:0]           cmdByte;
  logic                 isPup;

  // Known register offsets
  function automatic logic regKnown(input logic [7:0] a);
    regKnown = (a == psbs_pkg::OFS_CMD) || (a == psbs_pkg::OFS_STATUS) ||
               (a == psbs_pkg::OFS_BANK_ADDR) || (a == psbs_pkg::OFS_ROM_ADDR) ||
               (a == psbs_pkg::OFS_PHRASE) || (a == psbs_pkg::OFS_CTRL_ADDR) ||
               (a == psbs_pkg::OFS_SILENCE);
  endfunction : regKnown

  // ROM area of an address
  function automatic psbs_pkg::psbs_area_t areaOf(input logic [20:0] a);
    if (a <= psbs_pkg::CTRL_AREA_END) begin
      areaOf = psbs_pkg::AREA_CTRL;
    end else if (a < psbs_pkg::VOICE_AREA_BASE) begin
      areaOf = psbs_pkg::AREA_TEST;
    end else begin
      areaOf = psbs_pkg::AREA_VOICE;
    end
  endfunction : areaOf

  // Silence length kept inside its range
  function automatic logic [10:0] clampMs(input logic [31:0] v);
    if (v < 32'(psbs_pkg::SILENCE_MIN_MS)) begin
      clampMs = psbs_pkg::SILENCE_MIN_MS;
    end else if (v > 32'(psbs_pkg::SILENCE_MAX_MS)) begin
      clampMs = psbs_pkg::SILENCE_MAX_MS;
    end else begin
      clampMs = v[10:0];
    end
  endfunction : clampMs

  ////////////////////////////////////////////////////////////////////////////
  // Bank window mapping
  psbs_bank_map #(
    .ADDR_W (psbs_pkg::ROM_ADDR_W)
  ) u_map (
    .bankCount (r.bankCount),
    .selLo     (r.selLo),
    .selHi     (r.selHi),
    .inAddr    (r.inBankAddr),
    .physAddr  (physAddr)
  );

  // Write strobe and command byte
  assign wrAccess  = psel & penable & r.pready & pwrite;
  assign cmdStrobe = wrAccess & (paddr == psbs_pkg::OFS_CMD);
  assign cmdByte   = pwdata[7:0];
  assign isPup     = (cmdByte[7:2] == 6'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nxt = r;
    // Pin synchronisers, change counted when second and third agree
    nxt.rstSync   = {r.rstSync[1:0], resetInLow};
    nxt.selLoSync = {r.selLoSync[1:0], bankSelectLoPin};
    nxt.selHiSync = {r.selHiSync[1:0], bankSelectHiPin};
    if (r.rstSync[1] == r.rstSync[2]) begin
      nxt.rstLow = ~r.rstSync[2];
    end
    if (r.selLoSync[1] == r.selLoSync[2]) begin
      nxt.selLo = r.selLoSync[2];
    end
    if (r.selHiSync[1] == r.selHiSync[2]) begin
      nxt.selHi = r.selHiSync[2];
    end

    // Settings registers
    if (wrAccess && paddr == psbs_pkg::OFS_BANK_ADDR) begin
      nxt.inBankAddr = pwdata[20:0];
    end
    if (wrAccess && paddr == psbs_pkg::OFS_PHRASE) begin
      nxt.phrase = pwdata[psbs_pkg::PHRASE_W-1:0];
      nxt.format = psbs_pkg::psbs_fmt_t'(pwdata[psbs_pkg::PH_FMT_LSB +: 2]);
    end
    if (wrAccess && paddr == psbs_pkg::OFS_SILENCE) begin
      nxt.silenceMs = clampMs(pwdata);
    end

    // Command interpreter
    if (r.cnt != '0) begin
      nxt.cnt = r.cnt - 1'b1;
    end
    case (r.state)
      psbs_pkg::PWR_DOWN: begin
        if (cmdStrobe && isPup) begin
          nxt.bankCount = cmdByte[1:0];
          nxt.state     = psbs_pkg::OSC_STAB;
          nxt.cnt       = psbs_pkg::CNT_W'(psbs_pkg::OSC_STAB_CYCLES - 1);
        end
      end
      psbs_pkg::OSC_STAB: begin
        if (r.cnt == '0) begin
          nxt.state = psbs_pkg::CMD_WAIT;
        end
      end
      psbs_pkg::CMD_WAIT: begin
        if (cmdStrobe) begin
          if (cmdByte == psbs_pkg::CMD_POWER_DOWN_COMMAND) begin
            // only from the waiting state with both flags high
            if (r.readyFlag && r.busyFlag) begin
              nxt.state = psbs_pkg::POWER_DOWN_COMMAND_PROC;
              nxt.cnt   = psbs_pkg::CNT_W'(psbs_pkg::CMD_PROC_CYCLES - 1);
            end
          end else if (cmdByte == psbs_pkg::CMD_ANALOG_SETUP_COMMAND) begin
            if (!playActive) begin
              nxt.state = psbs_pkg::ANALOG_SETUP_COMMAND_ARG;
            end
          end else if (!isPup) begin
            nxt.state = psbs_pkg::CMD_PROC;
            nxt.cnt   = psbs_pkg::CNT_W'(psbs_pkg::CMD_PROC_CYCLES - 1);
          end
        end
      end
      psbs_pkg::ANALOG_SETUP_COMMAND_ARG: begin
        if (cmdStrobe) begin
          // amplifier powered only by analog setup
          nxt.ampOn = cmdByte[psbs_pkg::ANALOG_SETUP_COMMAND_SPEN];
          nxt.dacOn = cmdByte[psbs_pkg::ANALOG_SETUP_COMMAND_DAEN];
          nxt.state = psbs_pkg::CMD_PROC;
          nxt.cnt   = psbs_pkg::CNT_W'(psbs_pkg::CMD_PROC_CYCLES - 1);
        end
      end
      psbs_pkg::CMD_PROC: begin
        if (r.cnt == '0) begin
          nxt.state = psbs_pkg::CMD_WAIT;
        end
      end
      psbs_pkg::POWER_DOWN_COMMAND_PROC: begin
        if (r.cnt == '0) begin
          // busy pin returns high, device powered down
          nxt.state = psbs_pkg::PWR_DOWN;
        end
      end
      default: begin
        nxt.state = psbs_pkg::PWR_DOWN;
      end
    endcase

    if (nxt.rstLow) begin
      nxt.state = psbs_pkg::PWR_DOWN;
      nxt.cnt   = '0;
    end

    // every setting back to initial on power-down
    if (nxt.rstLow || (nxt.state == psbs_pkg::PWR_DOWN && r.state != psbs_pkg::PWR_DOWN)) begin
      nxt.bankCount  = psbs_pkg::BANKS_RESET;
      nxt.ampOn      = 1'b0;
      nxt.dacOn      = 1'b0;
      nxt.phrase     = '0;
      nxt.format     = psbs_pkg::FMT_ADAPTIVE4;
      nxt.silenceMs  = psbs_pkg::SILENCE_RESET;
      nxt.inBankAddr = '0;
    end

    // flags low while processing; busy flag also low while playing, ready flag while a channel waits
    nxt.readyFlag = (nxt.state inside {psbs_pkg::CMD_WAIT, psbs_pkg::ANALOG_SETUP_COMMAND_ARG}) &
                    ~channelWaiting;
    nxt.busyFlag  = (nxt.state == psbs_pkg::PWR_DOWN) ||
                    ((nxt.state inside {psbs_pkg::CMD_WAIT, psbs_pkg::ANALOG_SETUP_COMMAND_ARG}) & ~playActive);
    // busy pin low during command processing
    nxt.cmdBusyN  = ~(nxt.state == psbs_pkg::CMD_PROC || nxt.state == psbs_pkg::POWER_DOWN_COMMAND_PROC);
    // minus output floats once amplifier is off
    nxt.spmOeN    = ~nxt.ampOn;

    // Address outputs
    nxt.romAddr  = physAddr;
    // control entry of the selected phrase
    nxt.ctrlAddr = 21'(r.phrase) << psbs_pkg::CTRL_ENTRY_SHIFT;

    // APB answer, zero wait states
    nxt.pready  = psel & ~penable;
    nxt.pslverr = psel & ~penable & ~regKnown(paddr);
    nxt.prdata  = '0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        psbs_pkg::OFS_STATUS: begin
          nxt.prdata[psbs_pkg::ST_READY_BIT]     = r.readyFlag;
          nxt.prdata[psbs_pkg::ST_BUSY_BIT]      = r.busyFlag;
          nxt.prdata[psbs_pkg::ST_CBUSY_BIT]     = r.cmdBusyN;
          nxt.prdata[psbs_pkg::ST_BANKS_LSB +: 2] = r.bankCount;
          nxt.prdata[psbs_pkg::ST_AMP_BIT]       = r.ampOn;
          nxt.prdata[psbs_pkg::ST_AREA_LSB +: 2] = areaOf(r.inBankAddr);
          nxt.prdata[psbs_pkg::ST_PWR_BIT]       = (r.state == psbs_pkg::PWR_DOWN);
        end
        psbs_pkg::OFS_BANK_ADDR: begin
          nxt.prdata[20:0] = r.inBankAddr;
        end
        psbs_pkg::OFS_ROM_ADDR: begin
          nxt.prdata[20:0] = r.romAddr;
        end
        psbs_pkg::OFS_PHRASE: begin
          nxt.prdata[psbs_pkg::PHRASE_W-1:0]   = r.phrase;
          nxt.prdata[psbs_pkg::PH_FMT_LSB +: 2] = r.format;
        end
        psbs_pkg::OFS_CTRL_ADDR: begin
          nxt.prdata[20:0] = r.ctrlAddr;
        end
        psbs_pkg::OFS_SILENCE: begin
          nxt.prdata[10:0] = r.silenceMs;
        end
        default: begin
          nxt.prdata = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r           <= '0;
      r.state     <= psbs_pkg::PWR_DOWN;
      r.rstSync   <= 3'h7;
      r.cmdBusyN  <= 1'b1;
      r.busyFlag  <= 1'b1;
      r.spmOeN    <= 1'b1;
      r.silenceMs <= psbs_pkg::SILENCE_RESET;
    end else begin
      r <= nxt;
    end
  end

  // Outputs straight from the state image, speaker minus output tied low
  assign prdata             = r.prdata;
  assign pready             = r.pready;
  assign pslverr            = r.pslverr;
  assign commandBusyNPin    = r.cmdBusyN;
  assign commandReadyFlag   = r.readyFlag;
  assign playbackBusyFlag   = r.busyFlag;
  assign ampPowered         = r.ampOn;
  assign dacPowered         = r.dacOn;
  assign speakerMinusOut    = 1'b0;
  assign speakerMinusOutEnN = r.spmOeN;
  assign romAddr            = r.romAddr;
  assign bankCount          = r.bankCount;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_PUP_WAKE: assert property (
    r.state == psbs_pkg::PWR_DOWN && cmdStrobe && isPup && !nxt.rstLow
    |=> r.state == psbs_pkg::OSC_STAB && r.bankCount == $past(cmdByte[1:0]))
    else $error("power-up did not start stabilisation");

  AST_PUP_IGNORED: assert property (
    r.state == psbs_pkg::CMD_WAIT && cmdStrobe && isPup && !nxt.rstLow
    |=> $stable(r.bankCount) && r.state == psbs_pkg::CMD_WAIT)
    else $error("power-up acted on outside power-down");

  AST_RST_FORCE: assert property (
    r.rstLow |=> r.state == psbs_pkg::PWR_DOWN && r.bankCount == 2'h0)
    else $error("reset pin did not force power-down");

  AST_OSC_IGNORE: assert property (
    r.state == psbs_pkg::OSC_STAB && r.cnt != '0
    |=> r.state inside {psbs_pkg::OSC_STAB, psbs_pkg::PWR_DOWN} && !r.ampOn)
    else $error("command taken during stabilisation");

  AST_POWER_DOWN_COMMAND_ACCEPT: assert property (
    r.state == psbs_pkg::CMD_WAIT && cmdStrobe && cmdByte == psbs_pkg::CMD_POWER_DOWN_COMMAND &&
    !nxt.rstLow |=> r.state == (($past(r.readyFlag) && $past(r.busyFlag)) ?
    psbs_pkg::POWER_DOWN_COMMAND_PROC : psbs_pkg::CMD_WAIT))
    else $error("power-down acceptance wrong");

  AST_POWER_DOWN_COMMAND_END: assert property (
    r.state == psbs_pkg::POWER_DOWN_COMMAND_PROC && r.cnt == '0
    |=> r.state == psbs_pkg::PWR_DOWN && r.bankCount == 2'h0 && !r.ampOn && r.cmdBusyN
    ##1 r.spmOeN)
    else $error("power-down end incomplete");

  AST_ONE_BANK: assert property (
    r.bankCount == 2'h0 |-> physAddr == r.inBankAddr)
    else $error("single bank address wrong");

  AST_TWO_BANK: assert property (
    r.bankCount == 2'h1 |-> physAddr == {r.selLo, r.inBankAddr[19:0]})
    else $error("two bank address wrong");

  AST_FOUR_BANK: assert property (
    r.bankCount[1] |-> physAddr == {r.selHi, r.selLo, r.inBankAddr[18:0]})
    else $error("four bank address wrong");

  AST_FLAGS_LOW: assert property (
    r.state == psbs_pkg::CMD_PROC || r.state == psbs_pkg::POWER_DOWN_COMMAND_PROC
    |-> !r.readyFlag && !r.busyFlag && !r.cmdBusyN)
    else $error("flags high while processing");

  AST_SILENCE: assert property (
    r.silenceMs >= psbs_pkg::SILENCE_MIN_MS && r.silenceMs <= psbs_pkg::SILENCE_MAX_MS)
    else $error("silence length out of range");

  COV_WAKE: cover property (r.state == psbs_pkg::OSC_STAB ##1 r.state == psbs_pkg::CMD_WAIT);
  COV_POWER_DOWN_COMMAND: cover property (r.state == psbs_pkg::POWER_DOWN_COMMAND_PROC ##1 r.state == psbs_pkg::PWR_DOWN);
  COV_ANALOG_SETUP_COMMAND: cover property (r.state == psbs_pkg::ANALOG_SETUP_COMMAND_ARG ##1 r.ampOn);
  COV_FOUR: cover property (r.bankCount == 2'h3 && r.selHi && r.selLo);

endmodule : psbs_ctrl

// *** design/psbs_pkg.sv ***
// Constants, command codes, state and register-image types for the power state bank select block
package psbs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned REF_CLK_MHZ      = 40;
  localparam int unsigned T_CMD_PROC_NS    = 5000;   // Command processing time
  localparam int unsigned T_OSC_STAB_US    = 100;    // Oscillator stabilisation time
  localparam int unsigned CMD_PROC_CYCLES  = (T_CMD_PROC_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int unsigned OSC_STAB_CYCLES  = T_OSC_STAB_US * REF_CLK_MHZ;
  localparam int unsigned CNT_W            = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CMD        = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_BANK_ADDR  = 8'h08;
  localparam logic [7:0] OFS_ROM_ADDR   = 8'h0C;
  localparam logic [7:0] OFS_PHRASE     = 8'h10;
  localparam logic [7:0] OFS_CTRL_ADDR  = 8'h14;
  localparam logic [7:0] OFS_SILENCE    = 8'h18;

  // Status and phrase format field positions
  localparam int unsigned ST_READY_BIT  = 0;
  localparam int unsigned ST_BUSY_BIT   = 5;
  localparam int unsigned ST_CBUSY_BIT  = 8;
  localparam int unsigned ST_BANKS_LSB  = 9;
  localparam int unsigned ST_AMP_BIT    = 11;
  localparam int unsigned ST_AREA_LSB   = 12;
  localparam int unsigned ST_PWR_BIT    = 14;
  localparam int unsigned PH_FMT_LSB    = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Command bytes
  localparam logic [7:0] CMD_POWER_DOWN_COMMAND       = 8'h20;
  localparam logic [7:0] CMD_ANALOG_SETUP_COMMAND      = 8'h04;
  localparam int unsigned ANALOG_SETUP_COMMAND_SPEN    = 1;
  localparam int unsigned ANALOG_SETUP_COMMAND_DAEN    = 2;

  ////////////////////////////////////////////////////////////////////////////
  // ROM layout and phrase capacity
  localparam int unsigned ROM_ADDR_W      = 21;
  localparam logic [20:0] CTRL_AREA_END   = 21'h00_1FFF;
  localparam logic [20:0] TEST_AREA_BASE  = 21'h00_2000;
  localparam logic [20:0] VOICE_AREA_BASE = 21'h00_2060;
  localparam int unsigned PHRASES_PER_BANK = 1024;
  localparam int unsigned PHRASE_W        = 10;
  localparam int unsigned CTRL_ENTRY_SHIFT = 3;       // Bytes per phrase entry as power of two
  localparam logic [10:0] SILENCE_MIN_MS  = 11'h014;
  localparam logic [10:0] SILENCE_MAX_MS  = 11'h400;

  // Reset values
  localparam logic [1:0]  BANKS_RESET     = 2'h0;
  localparam logic [10:0] SILENCE_RESET   = 11'h014;

  typedef enum logic [1:0] {
    AREA_CTRL, AREA_TEST, AREA_VOICE
  } psbs_area_t;

  typedef enum logic [1:0] {
    FMT_ADAPTIVE4, FMT_NONLIN8, FMT_LINEAR8, FMT_LINEAR16
  } psbs_fmt_t;

  typedef enum logic [2:0] {
    PWR_DOWN, OSC_STAB, CMD_WAIT, CMD_PROC, ANALOG_SETUP_COMMAND_ARG, POWER_DOWN_COMMAND_PROC
  } psbs_state_t;

  typedef struct packed {
    psbs_state_t      state;
    logic [CNT_W-1:0] cnt;
    logic [2:0]       rstSync;
    logic [2:0]       selLoSync;
    logic [2:0]       selHiSync;
    logic             rstLow;
    logic             selLo;
    logic             selHi;
    logic [1:0]       bankCount;
    logic             ampOn;
    logic             dacOn;
    logic             cmdBusyN;
    logic             readyFlag;
    logic             busyFlag;
    logic             spmOeN;
    logic [9:0]       phrase;
    psbs_fmt_t        format;
    logic [10:0]      silenceMs;
    logic [20:0]      inBankAddr;
    logic [20:0]      romAddr;
    logic [20:0]      ctrlAddr;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } psbs_regs_t;

endpackage : psbs_pkg

// *** design/psbs_bank_map.sv ***
// Bank window mapping from bank count and select pins to a physical ROM address
module psbs_bank_map #(
  parameter int unsigned ADDR_W = 21
) (
  input  wire logic [1:0]        bankCount,
  input  wire logic              selLo,
  input  wire logic              selHi,
  input  wire logic [ADDR_W-1:0] inAddr,
  output logic      [ADDR_W-1:0] physAddr
);

  ////////////////////////////////////////////////////////////////////////////
  // Base plus offset within the selected window
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] offs;

  always_comb begin
    case (bankCount)
      2'h0: begin
        base = '0;
        offs = inAddr;
      end
      2'h1: begin
        base = {selLo, {(ADDR_W-1){1'b0}}};
        offs = {1'b0, inAddr[ADDR_W-2:0]};
      end
      default: begin
        // four quarters, code three same as four
        base = {selHi, selLo, {(ADDR_W-2){1'b0}}};
        offs = {2'b00, inAddr[ADDR_W-3:0]};
      end
    endcase
    physAddr = base + offs;
  end

endmodule : psbs_bank_map

// *** testbench/psbs_host_model.sv ***
// Host-side APB master model that issues register accesses and command bytes
module psbs_host_model (
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic hung = 1'b0;

  // Bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One transfer, held until pready is sampled high or 16 access edges pass, then one idle edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    hung = (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;  // Released data no longer shows the last word
    @(posedge ref_clk);
  endtask : xfer

endmodule : psbs_host_model

// *** testbench/power_state_bank_select_tb.sv ***
// Self-checking bench for the power state and bank select block
module power_state_bank_select_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        resetInLow = 1'b1;
  logic        selLo = 1'b0;
  logic        selHi = 1'b0;
  logic        playActive = 1'b0;
  logic        channelWaiting = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err, cmdBusyN, ready, busy, amp, dac, speaker_minus_out, spmEnN;
  logic [20:0] romAddr;
  logic [1:0]  bankCount;
  int          n_mismatch = 0;
  int          n_checks = 0;

  // Clock of 25 ns
  always #12.5 ref_clk = ~ref_clk;

  psbs_ctrl uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .resetInLow(resetInLow), .bankSelectLoPin(selLo),
    .bankSelectHiPin(selHi), .playActive(playActive), .channelWaiting(channelWaiting),
    .commandBusyNPin(cmdBusyN), .commandReadyFlag(ready), .playbackBusyFlag(busy),
    .ampPowered(amp), .dacPowered(dac), .speakerMinusOut(speaker_minus_out),
    .speakerMinusOutEnN(spmEnN), .romAddr(romAddr), .bankCount(bankCount));

  psbs_host_model host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Register access through the host model, hang ends the run
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    host.xfer(wr, a, d, rd, err);
    if (host.hung) begin
      n_mismatch++;
      finish_test();
    end
  endtask : acc

  // Bounded wait for a signal to go high
  task automatic waitHigh(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (s !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
  endtask : waitHigh

  // Expected physical address for offset 0x1234 in the selected window
  function automatic logic [20:0] expAddr(input logic [1:0] c, input logic [1:0] s);
    logic [20:0] off;
    off = 21'h00_1234;
    if (c == 2'h0) return off;
    if (c == 2'h1) return {s[0], 20'h0_0000} + off;
    return {s, 19'h0_0000} + off;
  endfunction : expAddr

  ////////////////////////////////////////////////////////////////////////////
  // Power-down image after reset, unmapped access
  task automatic t_reset();
    chk({cmdBusyN, ready, busy, bankCount, amp, spmEnN}, 32'h0000_0051, "reset pins");
    acc(1'b0, psbs_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd[14], 1'b1, "status power-down");
    acc(1'b0, 8'hFC, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped read data");
    chk(err, 1'b1, "unmapped read error");
  endtask : t_reset

  // Phrase entry, sample format, silence limits and ROM areas
  task automatic t_regs();
    acc(1'b1, psbs_pkg::OFS_PHRASE, 32'h0000_37FF);
    acc(1'b0, psbs_pkg::OFS_PHRASE, 32'h0000_0000);
    chk(rd, 32'h0000_33FF, "phrase and format");
    acc(1'b0, psbs_pkg::OFS_CTRL_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_1FF8, "control entry");
    acc(1'b1, psbs_pkg::OFS_SILENCE, 32'h0000_0005);
    acc(1'b0, psbs_pkg::OFS_SILENCE, 32'h0000_0000);
    chk(rd, 32'h0000_0014, "silence floor");
    acc(1'b1, psbs_pkg::OFS_SILENCE, 32'h0000_0800);
    acc(1'b0, psbs_pkg::OFS_SILENCE, 32'h0000_0000);
    chk(rd, 32'h0000_0400, "silence ceiling");
    acc(1'b1, psbs_pkg::OFS_SILENCE, 32'h0000_0064);
    acc(1'b0, psbs_pkg::OFS_SILENCE, 32'h0000_0000);
    chk(rd, 32'h0000_0064, "silence in range");
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, psbs_pkg::OFS_BANK_ADDR, 32'h0000_1FFF + 32'(i) * 32'h0000_0060);
      acc(1'b0, psbs_pkg::OFS_STATUS, 32'h0000_0000);
      chk(rd[13:12], i, "rom area");
    end
  endtask : t_regs

  // Power-up with one bank code, windows, amp setup, power-down
  task automatic t_bank(input logic [1:0] code);
    acc(1'b1, psbs_pkg::OFS_CMD, {30'h0000_0000, code});
    acc(1'b1, psbs_pkg::OFS_CMD, psbs_pkg::CMD_POWER_DOWN_COMMAND);
    waitHigh(ready, 4200);
    chk({cmdBusyN, amp}, 2'h2, "after power-up");
    acc(1'b1, psbs_pkg::OFS_CMD, 32'h0000_0000);
    chk({cmdBusyN, ready}, 2'h3, "second power-up");
    acc(1'b1, psbs_pkg::OFS_BANK_ADDR, 32'h0000_1234);
    for (int s = 0; s < 4; s++) begin
      selLo <= s[0];
      selHi <= s[1];
      repeat (8) @(posedge ref_clk);
      acc(1'b0, psbs_pkg::OFS_ROM_ADDR, 32'h0000_0000);
      chk(romAddr, expAddr(code, s[1:0]), "bank window pins");
      chk(rd[20:0], expAddr(code, s[1:0]), "bank window read");
    end
    channelWaiting <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(ready, 1'b0, "ready while channel waits");
    channelWaiting <= 1'b0;
    waitHigh(ready, 10);
    acc(1'b1, psbs_pkg::OFS_CMD, psbs_pkg::CMD_ANALOG_SETUP_COMMAND);
    waitHigh(ready, 300);
    acc(1'b1, psbs_pkg::OFS_CMD, 32'h0000_0006);
    waitHigh(ready, 300);
    chk({amp, dac, spmEnN, speaker_minus_out}, 4'hC, "amp powered");
    playActive <= 1'b1;
    repeat (2) @(posedge ref_clk);
    // playing, so power-down must be dropped
    acc(1'b1, psbs_pkg::OFS_CMD, psbs_pkg::CMD_POWER_DOWN_COMMAND);
    repeat (3) @(posedge ref_clk);
    chk({cmdBusyN, busy}, 2'h2, "power-down during play");
    playActive <= 1'b0;
    waitHigh(ready, 10);
    acc(1'b1, psbs_pkg::OFS_CMD, psbs_pkg::CMD_POWER_DOWN_COMMAND);
    chk(cmdBusyN, 1'b0, "power-down busy");
    waitHigh(cmdBusyN, 300);
    @(posedge ref_clk);
    chk({ready, bankCount, amp, dac, spmEnN}, 5'h01, "after power-down");
    acc(1'b0, psbs_pkg::OFS_PHRASE, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "phrase cleared");
    acc(1'b0, psbs_pkg::OFS_SILENCE, 32'h0000_0000);
    chk(rd, 32'h0000_0014, "silence cleared");
  endtask : t_bank

  // Reset pin low during stabilisation
  task automatic t_pin();
    acc(1'b1, psbs_pkg::OFS_CMD, 32'h0000_0002);
    repeat (10) @(posedge ref_clk);
    resetInLow <= 1'b0;
    repeat (6) @(posedge ref_clk);
    resetInLow <= 1'b1;
    repeat (6) @(posedge ref_clk);
    // power-down at once, bank count cleared
    chk({ready, busy, bankCount}, 4'h4, "reset pin");
    acc(1'b1, psbs_pkg::OFS_CMD, 32'h0000_0001);
    waitHigh(ready, 4200);
    chk(bankCount, 2'h1, "power-up after pin reset");
  endtask : t_pin

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_regs();
    for (int c = 0; c < 4; c++) begin
      t_bank(c[1:0]);
    end
    t_pin();
    finish_test();
  end

endmodule : power_state_bank_select_tb
